// file: rtl/lhi_host_if.sv
// host interface: parallel 68/80 bus and write-only serial link
`timescale 1ns/1ps
`default_nettype none
module lhi_host_if #(
  parameter int DEPTH = lhi_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial shift clock, its own domain
  input wire logic shift_clk,
  // mode straps
  input wire logic parallel_select,
  input wire logic bus_style_select,
  // host pins
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic hardware_reset_low,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  // words to the core: bit 8 high for display data, but always low for an aborted serial partial byte
  output logic core_valid,
  input wire logic core_ready,
  output logic [8:0] core_word,
  // display ram read port toward the core
  output logic ram_rd_req,
  input wire logic [7:0] ram_rd_data,
  input wire logic [7:0] status_byte,
  // lost byte when fifo is full
  output logic overflow
);
  // reset release through two flip-flops
  logic [1:0] rst_sync_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire rst_n = rst_sync_q[1];

  // pin synchronisers: cs, select, strobes, straps, hw reset
  localparam int NS = 7;
  wire [NS-1:0] raw = {hardware_reset_low, parallel_select,
    bus_style_select, chip_select_n, data_command_select,
    rd_strobe, wr_strobe};
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  // two flip-flops before any core-clock logic reads the pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 7'h4F;
      s2_q <= 7'h4F;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      d1_q <= data_in;
      d2_q <= d1_q;
    end
  end
  wire hw_rst_n = s2_q[6];
  wire par_mode = s2_q[5];
  wire style68 = s2_q[4];
  wire cs_n = s2_q[3];
  wire dc_sel = s2_q[2];
  wire rd_s = s2_q[1];
  wire wr_s = s2_q[0];

  // strobe decode: 68 style uses enable and read-not-write
  wire act68 = rd_s;                      // enable high is active
  wire rw68 = wr_s;
  wire rd_act = style68 ? (act68 && rw68) : !rd_s;
  wire wr_act = style68 ? (act68 && !rw68) : !wr_s;
  wire sel = par_mode && !cs_n && hw_rst_n;
  logic rd_prev_q;
  logic wr_prev_q;
  // one action per strobe: act on the strobe's leading edge
  wire rd_go = sel && rd_act && !rd_prev_q;
  wire wr_go = sel && wr_act && !wr_prev_q;
  wire rd_data_go = rd_go && dc_sel;
  wire rd_stat_go = rd_go && !dc_sel;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= sel && rd_act;
      wr_prev_q <= sel && wr_act;
    end
  end

  // bus holder: data read returns the value caught on the previous data read
  logic [7:0] hold_q;
  logic [7:0] dout_q;
  logic [7:0] oe_n_q;
  logic ram_rd_q;
  logic rd_fill_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= lhi_pkg::HOLD_RST;
      dout_q <= 8'h00;
      oe_n_q <= 8'hFF;
      ram_rd_q <= 1'b0;
      rd_fill_q <= 1'b0;
    end else begin
      ram_rd_q <= rd_data_go;
      rd_fill_q <= ram_rd_q;
      if (rd_data_go) dout_q <= hold_q;
      else if (rd_stat_go) dout_q <= status_byte;
      if (rd_fill_q) hold_q <= ram_rd_data;
      // drive only while selected in parallel mode and reading
      oe_n_q <= (sel && rd_act) ? 8'h00 : 8'hFF;
    end
  end
  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;
  assign ram_rd_req = ram_rd_q;

  // serial domain: shifter and counter on the shift clock
  // deselect or hw reset clears them asynchronously
  wire ser_clr_n = !chip_select_n && hardware_reset_low
    && !parallel_select;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic [7:0] sbyte_q;
  logic skind_q;
  logic stog_q;
  always_ff @(posedge shift_clk or negedge ser_clr_n) begin
    if (!ser_clr_n) begin
      sh_q <= lhi_pkg::SHIFT_RST;
      cnt_q <= lhi_pkg::BIT_CNT_RST;
    end else begin
      sh_q <= {sh_q[6:0], data_in[7]};
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // byte capture on the eighth edge, kept past deselect
  always_ff @(posedge shift_clk or negedge rstn) begin
    if (!rstn) begin
      sbyte_q <= 8'h00;
      skind_q <= lhi_pkg::KIND_CMD;
      stog_q <= 1'b0;
    end else if (ser_clr_n && cnt_q == 3'h7) begin
      sbyte_q <= {sh_q[6:0], data_in[7]};
      skind_q <= data_command_select;
      stog_q <= !stog_q;
    end
  end
  // partial-byte snapshot: counter and shifter seen by the core domain;
  // the shift clock is idle whenever these are used, so the multi-bit
  // copies have settled and need no gray code
  logic [2:0] c1_q;
  logic [2:0] c2_q;
  logic [2:0] c3_q; // one stage later: still holds the count after clear
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] p3_q; // partial byte as it stood before the clear
  logic [2:0] t_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic k1_q;
  logic k2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_q <= 3'h0;
      c2_q <= 3'h0;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      c3_q <= 3'h0;
      p3_q <= 8'h00;
      t_q <= 3'h0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      k1_q <= 1'b0;
      k2_q <= 1'b0;
    end else begin
      c1_q <= cnt_q;
      c2_q <= c1_q;
      p1_q <= sh_q;
      p2_q <= p1_q;
      c3_q <= c2_q;
      p3_q <= p2_q;
      t_q <= {t_q[1:0], stog_q};
      b1_q <= sbyte_q;
      b2_q <= b1_q;
      k1_q <= skind_q;
      k2_q <= k1_q;
    end
  end
  // byte is stable long before its toggle is seen twice-synchronised
  wire ser_byte_go = t_q[2] != t_q[1];
  // cs rise or hw reset fall in serial mode with bits pending; the pin
  // clears the shifter at once while its synchronised copy lags two
  // edges, so only the third stage still shows the partial byte then
  wire ser_abort = !par_mode && (cs_n || !hw_rst_n)
    && (c3_q != 3'h0);
  logic abort_done_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) abort_done_q <= 1'b0;
    else abort_done_q <= ser_abort;
  end
  wire abort_go = ser_abort && !abort_done_q;

  // fifo feed: parallel writes, serial bytes, aborted partials
  logic [8:0] in_word;
  logic in_valid;
  logic [7:0] wr_hold_q;
  logic wr_have_q;
  always_comb begin
    in_valid = 1'b0;
    in_word = 9'h000;
    if (wr_go && !dc_sel) begin
      in_valid = 1'b1;
      in_word = {lhi_pkg::KIND_CMD, d2_q};
    end else if (wr_go && wr_have_q) begin
      in_valid = 1'b1;
      in_word = {lhi_pkg::KIND_DATA, wr_hold_q};
    end else if (ser_byte_go) begin
      in_valid = 1'b1;
      in_word = {k2_q, b2_q};
    end else if (abort_go) begin
      in_valid = 1'b1;
      in_word = {lhi_pkg::KIND_CMD, p3_q};
    end
  end
  // data write held in the bus holder until the next data write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hold_q <= 8'h00;
      wr_have_q <= 1'b0;
    end else if (wr_go && dc_sel) begin
      wr_hold_q <= d2_q;
      wr_have_q <= 1'b1;
    end
  end
  wire in_ready;
  wire f_valid;
  wire [8:0] f_data;
  lhi_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(f_valid),
    .out_ready(!core_valid),
    .out_data(f_data)
  );
  // output stage registered so outputs come from flip-flops; valid does
  // not wait for ready, so a stalled core sees its word held steady
  logic cv_q;
  logic [8:0] cw_q;
  logic ovf_q;
  wire load_out = !cv_q && f_valid; // next fifo word into the output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cv_q <= 1'b0;
      cw_q <= 9'h000;
      ovf_q <= 1'b0;
    end else begin
      if (core_valid && core_ready) cv_q <= 1'b0;
      else if (load_out) cv_q <= 1'b1;
      if (load_out) cw_q <= f_data;
      ovf_q <= in_valid && !in_ready;
    end
  end
  assign core_valid = cv_q;
  assign core_word = cw_q;
  assign overflow = ovf_q;
endmodule

// small synchronous fifo with valid/ready on both sides
module lhi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];   // storage in flip-flops
  logic [AW-1:0] wr_q;               // write index
  logic [AW-1:0] rd_q;               // read index
  logic [AW:0] cnt_q;                // words held
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  // indices and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  // storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule
`default_nettype wire

// file: rtl/lhi_pkg.sv
// constants shared by the display driver host interface
package lhi_pkg;
  localparam int DATA_W = 8;            // parallel bus width
  localparam int BIT_CNT_W = 3;         // serial bit counter width
  localparam int FIFO_DEPTH = 16;       // words buffered toward the core
  localparam logic [2:0] BIT_CNT_RST = 3'h0;  // counter after reset
  localparam logic [7:0] SHIFT_RST = 8'h00;   // shift register after reset
  localparam logic [7:0] HOLD_RST = 8'h00;    // bus holder after reset
  localparam int SYNC_STAGES = 2;       // flip-flops in each synchroniser
  // kinds of word handed to the core: bit 8 of a fifo word
  localparam logic KIND_CMD = 1'b0;
  localparam logic KIND_DATA = 1'b1;
endpackage

// file: rtl/lhi_fifo.sv
// the host interface fifo module is defined in lhi_host_if.sv

// file: verif/lhi_host_if_chk.sv
// port checker for the host interface
`timescale 1ns/1ps
`default_nettype none
module lhi_host_if_chk #(parameter int DEPTH = 16) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // host pins
  input wire logic parallel_select,
  input wire logic chip_select_n,
  input wire logic hardware_reset_low,
  // outputs watched
  input wire logic [7:0] data_oe_n,
  input wire logic ram_rd_req,
  input wire logic core_valid,
  input wire logic core_ready,
  input wire logic [8:0] core_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // pins cross synchronisers, so each level is given time to land
  sequence s_desel; chip_select_n[*4]; endsequence
  sequence s_ser; (!parallel_select)[*4]; endsequence
  sequence s_hw; (!hardware_reset_low)[*5]; endsequence
  a_desel_bus_off:
    assert property (s_desel |-> data_oe_n == 8'hFF) else $error("bus on");
  a_desel_no_read:
    assert property (s_desel |-> !ram_rd_req) else $error("desel read");
  a_serial_bus_off:
    assert property (s_ser |-> data_oe_n == 8'hFF) else $error("serial bus");
  a_serial_no_read:
    assert property (s_ser |-> !ram_rd_req) else $error("serial read");
  a_hw_no_read:
    assert property (s_hw |-> !ram_rd_req) else $error("read in reset");
  a_read_one_pulse:
    assert property (ram_rd_req |=> !ram_rd_req) else $error("long read");
  a_read_drives_bus:
    assert property (ram_rd_req |-> ##[0:2] data_oe_n == 8'h00)
      else $error("read not driven");
  a_word_held:
    assert property (core_valid && !core_ready |=>
      core_valid && $stable(core_word)) else $error("word dropped");
endmodule
bind lhi_host_if lhi_host_if_chk #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .parallel_select(parallel_select),
  .chip_select_n(chip_select_n), .hardware_reset_low(hardware_reset_low),
  .data_oe_n(data_oe_n), .ram_rd_req(ram_rd_req), .core_valid(core_valid),
  .core_ready(core_ready), .core_word(core_word));
`default_nettype wire

// file: verif/lhi_core_model.sv
// core side model: display ram read port and word sink
`timescale 1ns/1ps
`default_nettype none
module lhi_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // core takes no words when high
  input wire logic stall,
  // toward the interface
  input wire logic ram_rd_req,
  output logic [7:0] ram_rd_data,
  output logic core_ready
);
  logic [7:0] cnt_q; // reads served
  // answer the cycle after a request; otherwise toggle so a late
  // sample never matches by luck
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      ram_rd_data <= 8'h00;
    end else if (ram_rd_req) begin
      cnt_q <= cnt_q + 8'h01;
      ram_rd_data <= 8'h40 + cnt_q;
    end else begin
      ram_rd_data <= ~ram_rd_data;
    end
  end
  assign core_ready = !stall; // stalled core lets the fifo fill
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the host interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
  comparisons++; \
  if ((gt) !== (ex)) begin \
    err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
  end \
end
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic shift_clk = 1'b0; // stands still outside frames
  logic parallel_select = 1'b1;
  logic bus_style_select = 1'b0;
  logic chip_select_n = 1'b1;
  logic data_command_select = 1'b0;
  logic hardware_reset_low = 1'b1;
  logic rd_strobe = 1'b1;
  logic wr_strobe = 1'b1;
  logic [7:0] data_in = 8'h00;
  logic [7:0] status_byte = 8'h3C;
  logic stall = 1'b0;
  logic [7:0] data_out, data_oe_n, ram_rd_data, rd_val;
  logic [8:0] core_word;
  logic core_valid, core_ready, ram_rd_req, overflow;
  logic [8:0] got[$];
  logic [8:0] exp_q[$];
  int err_count = 0;
  int comparisons = 0;
  int ovf_cnt = 0;
  always #2.5 core_clk = ~core_clk;
  lhi_host_if #(.DEPTH(16)) uut (
    .core_clk(core_clk), .rstn(rstn), .shift_clk(shift_clk),
    .parallel_select(parallel_select), .bus_style_select(bus_style_select),
    .chip_select_n(chip_select_n), .data_command_select(data_command_select),
    .hardware_reset_low(hardware_reset_low), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .core_valid(core_valid), .core_ready(core_ready),
    .core_word(core_word), .ram_rd_req(ram_rd_req),
    .ram_rd_data(ram_rd_data), .status_byte(status_byte),
    .overflow(overflow));
  lhi_core_model u_core (.core_clk(core_clk), .rstn(rstn), .stall(stall),
    .ram_rd_req(ram_rd_req), .ram_rd_data(ram_rd_data),
    .core_ready(core_ready));
  // log every accepted word and every lost byte
  always @(posedge core_clk) begin
    if (core_valid === 1'b1 && core_ready === 1'b1) got.push_back(core_word);
    if (overflow === 1'b1) ovf_cnt++;
  end
  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one parallel cycle; strobe held well past the synchroniser
  task automatic pbus(input logic rd, input logic dcs, input logic [7:0] wd,
                      input logic csn);
    @(posedge core_clk);
    chip_select_n <= csn;
    data_command_select <= dcs;
    data_in <= wd;
    wr_strobe <= rd; // 68 read/write level or 80 write strobe
    rd_strobe <= bus_style_select ? 1'b1 : !rd;
    repeat (8) @(posedge core_clk);
    rd_val = data_out;
    rd_strobe <= !bus_style_select;
    wr_strobe <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  // n serial bits msb first on a 64 ns link clock, then deselect
  task automatic sbyte(input logic [7:0] b, input int n, input logic dcs);
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    data_command_select <= dcs;
    repeat (4) @(posedge core_clk);
    #1.3;
    for (int i = 0; i < n; i++) begin
      data_in[7] = b[7-i];
      #32 shift_clk = 1'b1;
      #32 shift_clk = 1'b0;
    end
    data_in[7] = ~data_in[7]; // line no longer valid
    repeat (8) @(posedge core_clk);
    chip_select_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic want(input logic k, input logic [7:0] b);
    exp_q.push_back({k, b});
  endtask
  // bounded wait for the expected words, then compare in order
  task automatic settle;
    logic [8:0] e;
    logic [8:0] g;
    int t;
    t = 0;
    while (got.size() < exp_q.size() && t < 600) begin
      @(posedge core_clk);
      t++;
    end
    if (got.size() < exp_q.size()) begin
      err_count++;
      $display("CHECK FAILED word wait expected %0d seen %0d",
               exp_q.size(), got.size());
      wrap_up();
    end
    repeat (20) @(posedge core_clk);
    `CHK("word count", exp_q.size(), got.size())
    while (exp_q.size() > 0 && got.size() > 0) begin
      e = exp_q.pop_front();
      g = got.pop_front();
      `CHK("core word", e, g)
    end
    exp_q.delete();
    got.delete();
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    chip_select_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    pbus(1, 1, 8'h00, 0);
    `CHK("dummy read", lhi_pkg::HOLD_RST, rd_val)
    pbus(1, 1, 8'h00, 0);
    `CHK("ram read", 8'h40, rd_val)
    pbus(1, 0, 8'h00, 0);
    `CHK("status read", 8'h3C, rd_val)
    // 68 style idles with its enable low: switch style and enable
    // together, or the idle levels would read as a status read
    bus_style_select <= 1'b1;
    rd_strobe <= 1'b0;
    pbus(1, 1, 8'h00, 0);
    `CHK("68 read", 8'h41, rd_val)
    pbus(0, 0, 8'h5A, 0);
    want(lhi_pkg::KIND_CMD, 8'h5A);
    bus_style_select <= 1'b0;
    rd_strobe <= 1'b1;
    pbus(0, 0, 8'hA5, 0);
    want(lhi_pkg::KIND_CMD, 8'hA5);
    pbus(0, 1, 8'hD1, 0);
    pbus(0, 1, 8'hD2, 0);
    want(lhi_pkg::KIND_DATA, 8'hD1);
    pbus(0, 0, 8'h77, 1);
    hardware_reset_low <= 1'b0;
    pbus(0, 0, 8'h66, 0);
    hardware_reset_low <= 1'b1;
    chip_select_n <= 1'b1;
    parallel_select <= 1'b0;
    settle();
    sbyte(8'h96, 8, 0);
    want(lhi_pkg::KIND_CMD, 8'h96);
    sbyte(8'hA0, 3, 1);
    want(lhi_pkg::KIND_CMD, 8'h05);
    sbyte(8'h3C, 8, 0);
    want(lhi_pkg::KIND_CMD, 8'h3C);
    settle();
    parallel_select <= 1'b1;
    stall <= 1'b1;
    // one word waits in the output stage, sixteen in the fifo
    for (int i = 0; i < 18; i++) pbus(0, 0, 8'(i), 0);
    for (int i = 0; i < 17; i++) want(lhi_pkg::KIND_CMD, 8'(i));
    `CHK("lost bytes", 1, ovf_cnt)
    stall <= 1'b0;
    settle();
    wrap_up();
  end
endmodule
`default_nettype wire
